// ==== jtag_scan.sv ====
// Purpose: Instruction decode, boundary, bypass, ID and config scan paths
// Assumes: Test pins are asynchronous; ref_clk far faster than the test clock
// Notes: Config write words pass a small FIFO toward the config logic
`timescale 1ns/1ps

module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [DEPTH-1:0] vld_reg;
   logic             pop;
   logic             push;

   initial if (DEPTH < 2) $error("word_fifo depth below 2");
   // Shift FIFO: head always sits in entry 0 so the output is a flop
   assign pop       = vld_reg[0] & out_ready;
   assign in_ready  = ~vld_reg[DEPTH-1] | pop;
   assign push      = in_valid & in_ready;
   assign out_data  = mem_reg[0];
   assign out_valid = vld_reg[0];

   for (genvar i = 0; i < DEPTH; i++)
   begin : g_ent
      logic nxt_vld;
      logic self_w;
      assign nxt_vld = (i < DEPTH - 1) ? vld_reg[(i + 1) % DEPTH] : 1'b0;
      assign self_w  = pop ? (nxt_vld == 1'b0 && vld_reg[i]) : (vld_reg[i] == 1'b0 &&
                       (i == 0 || vld_reg[(i + DEPTH - 1) % DEPTH]));
      always_ff @(posedge ref_clk or negedge nrst)
      begin
         if (!nrst)
         begin
            vld_reg[i] <= 1'b0;
            mem_reg[i] <= '0;
         end
         else
         begin
            if (push && self_w)
               mem_reg[i] <= in_data;
            else if (pop && nxt_vld)
               mem_reg[i] <= mem_reg[(i + 1) % DEPTH];
            vld_reg[i] <= (pop ? nxt_vld : vld_reg[i]) | (push & self_w);
         end
      end
   end
endmodule : word_fifo

module jtag_scan #(
   parameter int         NUM_IO      = 8,
   parameter int         NUM_DED_IN  = 2,
   parameter logic [3:0] DIE_VERSION = 4'h0,
   parameter logic [6:0] FAMILY      = 7'h01,
   parameter logic [8:0] CLB_ROWS    = 9'h010,
   parameter logic [10:0] COMPANY    = 11'h001
) (
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tdi,
   output logic                       tdo,
   output logic                       tdo_oe,
   input  wire logic [NUM_IO-1:0]     pad_in,
   output logic      [NUM_IO-1:0]     pad_out,
   output logic      [NUM_IO-1:0]     pad_oe,
   input  wire logic [NUM_IO-1:0]     core_out,
   input  wire logic [NUM_IO-1:0]     core_oe,
   output logic      [NUM_IO-1:0]     core_in,
   input  wire logic [NUM_DED_IN-1:0] ded_in,
   input  wire logic                  cfg_done,
   input  wire logic [31:0]           usercode,
   input  wire logic                  startup_clock_source,
   output logic                       startup_step,
   output logic      [31:0]           cfg_wr_data,
   output logic                       cfg_wr_valid,
   input  wire logic                  cfg_wr_ready,
   output logic                       cfg_overrun,
   input  wire logic [31:0]           cfg_rd_data,
   input  wire logic                  cfg_rd_valid,
   output logic                       cfg_rd_ack,
   output logic                       user_chain_one_select,
   output logic                       user_chain_two_select,
   output logic                       user_chain_one_shift_clock,
   output logic                       user_chain_two_shift_clock,
   output logic                       user_chain_tdi,
   input  wire logic                  user_chain_one_return,
   input  wire logic                  user_chain_two_return,
   output logic                       tap_reset_state,
   output logic                       tap_shift_state,
   output logic                       tap_update_state
);
   localparam int BSR_LEN = NUM_IO * jtag_pkg::CELLS_PER_IO + NUM_DED_IN;
   localparam int SYN_W   = 3 + NUM_IO + NUM_DED_IN;

   initial if (NUM_IO < 1 || NUM_DED_IN < 1) $error("jtag_scan needs pads");

   logic [SYN_W-1:0]      syn_meta_reg;
   logic [SYN_W-1:0]      syn_reg;
   logic                  tck_last_reg;
   logic                  tck_s, tms_s, tdi_s, tck_rise, tck_fall;
   logic [NUM_IO-1:0]     pad_s;
   logic [NUM_DED_IN-1:0] ded_s;
   jtag_pkg::tap_state_t  state_reg, state_next;
   logic [4:0]            ir_reg, ir_sreg, instr;
   logic                  known;
   logic                  bypass_reg;
   logic [BSR_LEN-1:0]    bsr_sreg, bsr_upd_reg, bsr_cap;
   logic [NUM_IO-1:0]     upd_in, upd_out, upd_oe;
   logic [31:0]           id_sreg, id_word, shifted;
   logic [4:0]            bit_cnt_reg;
   logic                  bsr_instr, extest, intest;
   logic                  push_valid_reg;
   logic [31:0]           push_data_reg;
   logic                  push_ready;

   // Sample the test pins, pad inputs and dedicated inputs through two flops
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         syn_meta_reg <= '0;
         syn_reg      <= '0;
         tck_last_reg <= 1'b0;
      end
      else
      begin
         syn_meta_reg <= {tck, tms, tdi, pad_in, ded_in};
         syn_reg      <= syn_meta_reg;
         tck_last_reg <= tck_s;
      end
   end

   assign {tck_s, tms_s, tdi_s, pad_s, ded_s} = syn_reg;
   assign tck_rise = tck_s & ~tck_last_reg;
   assign tck_fall = ~tck_s & tck_last_reg;

   always_comb
   begin
      case (state_reg)
         jtag_pkg::TAP_RESET:  state_next = tms_s ? jtag_pkg::TAP_RESET : jtag_pkg::TAP_IDLE;
         jtag_pkg::TAP_IDLE:   state_next = tms_s ? jtag_pkg::TAP_SEL_DR : jtag_pkg::TAP_IDLE;
         jtag_pkg::TAP_SEL_DR: state_next = tms_s ? jtag_pkg::TAP_SEL_IR : jtag_pkg::TAP_CAP_DR;
         jtag_pkg::TAP_CAP_DR: state_next = tms_s ? jtag_pkg::TAP_EX1_DR : jtag_pkg::TAP_SH_DR;
         jtag_pkg::TAP_SH_DR:  state_next = tms_s ? jtag_pkg::TAP_EX1_DR : jtag_pkg::TAP_SH_DR;
         jtag_pkg::TAP_EX1_DR: state_next = tms_s ? jtag_pkg::TAP_UPD_DR : jtag_pkg::TAP_PAU_DR;
         jtag_pkg::TAP_PAU_DR: state_next = tms_s ? jtag_pkg::TAP_EX2_DR : jtag_pkg::TAP_PAU_DR;
         jtag_pkg::TAP_EX2_DR: state_next = tms_s ? jtag_pkg::TAP_UPD_DR : jtag_pkg::TAP_SH_DR;
         jtag_pkg::TAP_UPD_DR: state_next = tms_s ? jtag_pkg::TAP_SEL_DR : jtag_pkg::TAP_IDLE;
         jtag_pkg::TAP_SEL_IR: state_next = tms_s ? jtag_pkg::TAP_RESET : jtag_pkg::TAP_CAP_IR;
         jtag_pkg::TAP_CAP_IR: state_next = tms_s ? jtag_pkg::TAP_EX1_IR : jtag_pkg::TAP_SH_IR;
         jtag_pkg::TAP_SH_IR:  state_next = tms_s ? jtag_pkg::TAP_EX1_IR : jtag_pkg::TAP_SH_IR;
         jtag_pkg::TAP_EX1_IR: state_next = tms_s ? jtag_pkg::TAP_UPD_IR : jtag_pkg::TAP_PAU_IR;
         jtag_pkg::TAP_PAU_IR: state_next = tms_s ? jtag_pkg::TAP_EX2_IR : jtag_pkg::TAP_PAU_IR;
         jtag_pkg::TAP_EX2_IR: state_next = tms_s ? jtag_pkg::TAP_UPD_IR : jtag_pkg::TAP_SH_IR;
         jtag_pkg::TAP_UPD_IR: state_next = tms_s ? jtag_pkg::TAP_SEL_DR : jtag_pkg::TAP_IDLE;
         default:              state_next = jtag_pkg::TAP_RESET;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         state_reg <= jtag_pkg::TAP_RESET;
      else if (tck_rise)
         state_reg <= state_next;
   end

   // Instruction register; update on the falling test clock edge
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ir_reg  <= jtag_pkg::IR_IDCODE;
         ir_sreg <= '0;
      end
      else if (state_reg == jtag_pkg::TAP_RESET)
         ir_reg <= jtag_pkg::IR_IDCODE;
      else if (tck_rise && state_reg == jtag_pkg::TAP_CAP_IR)
         ir_sreg <= jtag_pkg::IR_CAPTURE;
      else if (tck_rise && state_reg == jtag_pkg::TAP_SH_IR)
         ir_sreg <= {tdi_s, ir_sreg[4:1]};
      else if (tck_fall && state_reg == jtag_pkg::TAP_UPD_IR)
         ir_reg <= ir_sreg;
   end

   always_comb
   begin
      case (ir_reg)
         jtag_pkg::IR_EXTEST, jtag_pkg::IR_SAMPLE, jtag_pkg::IR_CFG_RD, jtag_pkg::IR_CFG_WR,
         jtag_pkg::IR_INTEST, jtag_pkg::IR_USERCODE, jtag_pkg::IR_IDCODE, jtag_pkg::IR_HIGHZ,
         jtag_pkg::IR_STARTUP, jtag_pkg::IR_BYPASS: known = 1'b1;
         jtag_pkg::IR_UCH_ONE, jtag_pkg::IR_UCH_TWO: known = cfg_done;
         default: known = 1'b0;
      endcase
      instr = known ? ir_reg : jtag_pkg::IR_BYPASS;
   end

   assign extest    = (instr == jtag_pkg::IR_EXTEST);
   assign intest    = (instr == jtag_pkg::IR_INTEST);
   assign bsr_instr = extest | intest | (instr == jtag_pkg::IR_SAMPLE);

   // Boundary cells: input, output, enable per pad, then input-only pins
   for (genvar k = 0; k < NUM_IO; k++)
   begin : g_io
      localparam int B = k * jtag_pkg::CELLS_PER_IO;
      assign bsr_cap[B + jtag_pkg::CELL_IN]  = pad_s[k];
      assign bsr_cap[B + jtag_pkg::CELL_OUT] = core_out[k];
      assign bsr_cap[B + jtag_pkg::CELL_OE]  = core_oe[k];
      assign upd_in[k]  = bsr_upd_reg[B + jtag_pkg::CELL_IN];
      assign upd_out[k] = bsr_upd_reg[B + jtag_pkg::CELL_OUT];
      assign upd_oe[k]  = bsr_upd_reg[B + jtag_pkg::CELL_OE];
   end
   for (genvar j = 0; j < NUM_DED_IN; j++)
   begin : g_ded
      assign bsr_cap[NUM_IO * jtag_pkg::CELLS_PER_IO + j] = ded_s[j];
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bsr_sreg    <= '0;
         bsr_upd_reg <= '0;
      end
      else if (bsr_instr)
      begin
         if (tck_rise && state_reg == jtag_pkg::TAP_CAP_DR)
            bsr_sreg <= bsr_cap;
         else if (tck_rise && state_reg == jtag_pkg::TAP_SH_DR)
            bsr_sreg <= {tdi_s, bsr_sreg[BSR_LEN-1:1]};
         else if (tck_fall && state_reg == jtag_pkg::TAP_UPD_DR)
            bsr_upd_reg <= bsr_sreg;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pad_out <= '0;
         pad_oe  <= '0;
         core_in <= '0;
      end
      else
      begin
         pad_out <= extest ? upd_out : core_out;
         pad_oe  <= (instr == jtag_pkg::IR_HIGHZ) ? '0 : (extest ? upd_oe : core_oe);
         core_in <= intest ? upd_in : pad_s;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         bypass_reg <= 1'b0;
      else if (tck_rise && state_reg == jtag_pkg::TAP_CAP_DR)
         bypass_reg <= 1'b0;
      else if (tck_rise && state_reg == jtag_pkg::TAP_SH_DR)
         bypass_reg <= tdi_s;
   end

   // Word register shared by ID, user ID and configuration transfers
   assign id_word = {DIE_VERSION, FAMILY, CLB_ROWS, COMPANY, 1'b1};
   assign shifted = {tdi_s, id_sreg[31:1]};

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         id_sreg     <= '0;
         bit_cnt_reg <= '0;
         cfg_rd_ack  <= 1'b0;
      end
      else
      begin
         cfg_rd_ack <= 1'b0;
         if (tck_rise && state_reg == jtag_pkg::TAP_CAP_DR)
         begin
            bit_cnt_reg <= '0;
            case (instr)
               jtag_pkg::IR_IDCODE:   id_sreg <= id_word;
               jtag_pkg::IR_USERCODE: id_sreg <= cfg_done ? usercode : jtag_pkg::USERCODE_UNCONF;
               jtag_pkg::IR_CFG_RD:
               begin
                  id_sreg    <= cfg_rd_valid ? cfg_rd_data : '0;
                  cfg_rd_ack <= cfg_rd_valid;
               end
               default: id_sreg <= id_sreg;
            endcase
         end
         else if (tck_rise && state_reg == jtag_pkg::TAP_SH_DR)
         begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (instr == jtag_pkg::IR_CFG_RD && bit_cnt_reg == 5'h1f)
            begin
               id_sreg    <= cfg_rd_valid ? cfg_rd_data : '0;
               cfg_rd_ack <= cfg_rd_valid;
            end
            else
               id_sreg <= shifted;
         end
      end
   end

   // Assembled write words wait here until the FIFO takes them
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         push_valid_reg <= 1'b0;
         push_data_reg  <= '0;
         cfg_overrun    <= 1'b0;
      end
      else
      begin
         if (push_valid_reg && push_ready)
            push_valid_reg <= 1'b0;
         if (tck_rise && state_reg == jtag_pkg::TAP_SH_DR &&
             instr == jtag_pkg::IR_CFG_WR && bit_cnt_reg == 5'h1f)
         begin
            if (push_valid_reg && !push_ready)
               cfg_overrun <= 1'b1;
            else
            begin
               push_valid_reg <= 1'b1;
               push_data_reg  <= shifted;
            end
         end
      end
   end

   word_fifo #(
      .WIDTH (jtag_pkg::WORD_W),
      .DEPTH (jtag_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .in_data   (push_data_reg),
      .in_valid  (push_valid_reg),
      .in_ready  (push_ready),
      .out_data  (cfg_wr_data),
      .out_valid (cfg_wr_valid),
      .out_ready (cfg_wr_ready)
   );

   // Test output changes on the falling test clock edge
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo_oe <= (state_reg == jtag_pkg::TAP_SH_DR) || (state_reg == jtag_pkg::TAP_SH_IR);
         if (state_reg == jtag_pkg::TAP_SH_IR)
            tdo <= ir_sreg[0];
         else
            case (instr)
               jtag_pkg::IR_EXTEST, jtag_pkg::IR_SAMPLE, jtag_pkg::IR_INTEST: tdo <= bsr_sreg[0];
               jtag_pkg::IR_IDCODE, jtag_pkg::IR_USERCODE,
               jtag_pkg::IR_CFG_RD, jtag_pkg::IR_CFG_WR: tdo <= id_sreg[0];
               jtag_pkg::IR_UCH_ONE: tdo <= user_chain_one_return;
               jtag_pkg::IR_UCH_TWO: tdo <= user_chain_two_return;
               default: tdo <= bypass_reg;
            endcase
      end
   end

   // User chain hookup and start-up stepping
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         user_chain_one_select      <= 1'b0;
         user_chain_two_select      <= 1'b0;
         user_chain_one_shift_clock <= 1'b0;
         user_chain_two_shift_clock <= 1'b0;
         user_chain_tdi             <= 1'b0;
         tap_reset_state            <= 1'b1;
         tap_shift_state            <= 1'b0;
         tap_update_state           <= 1'b0;
         startup_step               <= 1'b0;
      end
      else
      begin
         user_chain_one_select <= (instr == jtag_pkg::IR_UCH_ONE);
         user_chain_two_select <= (instr == jtag_pkg::IR_UCH_TWO);
         user_chain_one_shift_clock <= tck_s && instr == jtag_pkg::IR_UCH_ONE &&
            (state_reg == jtag_pkg::TAP_CAP_DR || state_reg == jtag_pkg::TAP_SH_DR);
         user_chain_two_shift_clock <= tck_s && instr == jtag_pkg::IR_UCH_TWO &&
            (state_reg == jtag_pkg::TAP_CAP_DR || state_reg == jtag_pkg::TAP_SH_DR);
         user_chain_tdi   <= tdi_s;
         tap_reset_state  <= (state_reg == jtag_pkg::TAP_RESET);
         tap_shift_state  <= (state_reg == jtag_pkg::TAP_SH_DR);
         tap_update_state <= (state_reg == jtag_pkg::TAP_UPD_DR);
         startup_step <= tck_rise && state_reg == jtag_pkg::TAP_IDLE &&
                         instr == jtag_pkg::IR_STARTUP && startup_clock_source;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   reserved_code_a: assert property (ir_reg == 5'h06 |-> instr == jtag_pkg::IR_BYPASS)
      else $error("reserved code not bypassed");
   user_unconf_a: assert property (!cfg_done && ir_reg == jtag_pkg::IR_UCH_ONE |->
      instr == jtag_pkg::IR_BYPASS) else $error("user chain usable before config");
   select_one_a: assert property (instr == jtag_pkg::IR_UCH_ONE |=> user_chain_one_select)
      else $error("chain one select missing");
   highz_pads_a: assert property (instr == jtag_pkg::IR_HIGHZ |=> pad_oe == '0)
      else $error("pads driven in high-z");
   extest_drive_a: assert property (extest |=> pad_out == $past(upd_out))
      else $error("pads not from boundary cells");
   intest_core_a: assert property (intest |=> core_in == $past(upd_in))
      else $error("core not from boundary cells");
   bypass_out_a: assert property (tck_fall && state_reg == jtag_pkg::TAP_SH_DR &&
      instr == jtag_pkg::IR_BYPASS |=> tdo == $past(bypass_reg) && tdo_oe)
      else $error("bypass bit not on output");
   idcode_lsb_a: assert property (tck_rise && state_reg == jtag_pkg::TAP_CAP_DR &&
      instr == jtag_pkg::IR_IDCODE |=> id_sreg[0]) else $error("id lsb not one");
   usercode_unconf_a: assert property (tck_rise && state_reg == jtag_pkg::TAP_CAP_DR &&
      instr == jtag_pkg::IR_USERCODE && !cfg_done |=> id_sreg == jtag_pkg::USERCODE_UNCONF)
      else $error("user id leaked before config");
   reset_out_a: assert property (state_reg == jtag_pkg::TAP_RESET |=> tap_reset_state)
      else $error("reset state not exported");

   startup_c: cover property (startup_step);
   cfg_push_c: cover property (push_valid_reg && push_ready);
   user_shift_c: cover property (user_chain_two_shift_clock);
endmodule : jtag_scan

// ==== jtag_pkg.sv ====
// Purpose: Constants for the boundary-scan instruction and data registers
// Assumes: Instruction codes are 5 bits
// Notes: Identity field defaults live in the top module as parameters
package jtag_pkg;
   localparam int IR_W = 5;
   localparam logic [4:0] IR_EXTEST   = 5'h00;
   localparam logic [4:0] IR_SAMPLE   = 5'h01;
   localparam logic [4:0] IR_UCH_ONE  = 5'h02;
   localparam logic [4:0] IR_UCH_TWO  = 5'h03;
   localparam logic [4:0] IR_CFG_RD   = 5'h04;
   localparam logic [4:0] IR_CFG_WR   = 5'h05;
   localparam logic [4:0] IR_INTEST   = 5'h07;
   localparam logic [4:0] IR_USERCODE = 5'h08;
   localparam logic [4:0] IR_IDCODE   = 5'h09;
   localparam logic [4:0] IR_HIGHZ    = 5'h0a;
   localparam logic [4:0] IR_STARTUP  = 5'h0c;
   localparam logic [4:0] IR_BYPASS   = 5'h1f;
   localparam logic [4:0] IR_CAPTURE  = 5'h01;
   localparam int WORD_W = 32;
   localparam logic [31:0] USERCODE_UNCONF = 32'hffffffff;
   localparam int CELLS_PER_IO = 3;
   localparam int CELL_IN  = 0;
   localparam int CELL_OUT = 1;
   localparam int CELL_OE  = 2;
   localparam int FIFO_DEPTH = 4;
   typedef enum logic [3:0] {
      TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
      TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7,
      TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
      TAP_EX1_IR = 4'hc, TAP_PAU_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UPD_IR = 4'hf
   } tap_state_t;
endpackage : jtag_pkg

// ==== scan_ctl.sv ====
// Purpose: Test controller model driving the scan port
// Assumes: Test clock period 200 ns, still between frames
// Notes: Data out sampled at the end of each high phase
`timescale 1ns/1ps
module scan_ctl (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   task automatic step(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      #100 tck <= 1'b1;
      #100 o = tdo;
      tck <= 1'b0;
   endtask : step
   // One frame from idle back to idle; IR path when ir is set, n bits shifted LSB first
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic o;
      dout = '0;
      step(1'b1, 1'b0, o);
      if (ir)
         step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask : scan
endmodule : scan_ctl

// ==== jtag_instruction_scan_registers_test.sv ====
// Purpose: Self-checking bench for the scan instruction decoder
// Assumes: Default pad counts and identity fields
// Notes: Table rows cover shift-out paths; handshakes checked by hand
`timescale 1ns/1ps
module jtag_instruction_scan_registers_test;
   typedef struct {logic [4:0] code; int n; logic [31:0] din; logic [31:0] exp;} row_t;
   localparam logic [31:0] ID_WORD = {4'h0, 7'h01, 9'h010, 11'h001, 1'b1};
   logic        ref_clk = 1'b0, nrst = 1'b0, tck, tms, tdi, tdo, bit_o;
   logic        cfg_done = 1'b0, cfg_wr_ready = 1'b0, cfg_rd_valid = 1'b0, startup_clock_source = 1'b0;
   logic        user_chain_one_return = 1'b0, user_chain_two_return = 1'b0;
   logic        cfg_wr_valid, user_chain_one_select, user_chain_two_select;
   logic [7:0]  pad_in = 8'h81, core_out = 8'h3c, core_oe = 8'hff;
   logic [1:0]  ded_in = 2'h2;
   logic [31:0] usercode = 32'h0, cfg_rd_data = 32'h0, cfg_wr_data, seen;
   int          failures = 0, total_checks = 0;
   row_t        rows [8] = '{'{5'h09, 32, 32'h0, ID_WORD}, '{5'h1f, 8, 32'ha5, 32'h4a},
                             '{5'h06, 8, 32'ha5, 32'h4a}, '{5'h02, 8, 32'ha5, 32'h4a},
                             '{5'h0a, 8, 32'h5a, 32'hb4}, '{5'h08, 32, 32'h0, 32'hffffffff},
                             '{5'h00, 26, 32'h0, 32'h02b36da5}, '{5'h07, 26, 32'h0, 32'h02b36da5}};
   always #12.5 ref_clk = ~ref_clk;
   scan_ctl ctl (.tck, .tms, .tdi, .tdo);
   jtag_scan DUT (.ref_clk, .nrst, .tck, .tms, .tdi, .tdo, .tdo_oe(), .pad_in, .pad_out(), .pad_oe(),
      .core_out, .core_oe, .core_in(), .ded_in, .cfg_done, .usercode, .startup_clock_source,
      .startup_step(), .cfg_wr_data, .cfg_wr_valid, .cfg_wr_ready, .cfg_overrun(), .cfg_rd_data,
      .cfg_rd_valid, .cfg_rd_ack(), .user_chain_one_select, .user_chain_two_select,
      .user_chain_one_shift_clock(), .user_chain_two_shift_clock(), .user_chain_tdi(),
      .user_chain_one_return, .user_chain_two_return, .tap_reset_state(), .tap_shift_state(),
      .tap_update_state());
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic close_out;
      $display("Checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   initial
   begin
      #1ms;
      failures++;
      close_out;
   end
   initial
   begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      ctl.step(1'b0, 1'b0, bit_o);
      foreach (rows[i])
      begin
         ctl.scan(1'b1, 5, {27'h0, rows[i].code}, seen);
         chk("instruction capture", seen, 32'h01);
         ctl.scan(1'b0, rows[i].n, rows[i].din, seen);
         chk("data shift", seen, rows[i].exp);
      end
      @(posedge ref_clk);
      cfg_done <= 1'b1;
      usercode <= 32'h1234_5678;
      user_chain_one_return <= 1'b1;
      ctl.scan(1'b1, 5, 32'h08, seen);
      ctl.scan(1'b0, 32, 32'h0, seen);
      chk("usercode", seen, 32'h1234_5678);
      ctl.scan(1'b1, 5, 32'h02, seen);
      chk("selects", {30'h0, user_chain_two_select, user_chain_one_select}, 32'h1);
      ctl.scan(1'b0, 8, 32'h0, seen);
      chk("chain one", seen, 32'hff);
      ctl.scan(1'b1, 5, 32'h03, seen);
      chk("selects", {30'h0, user_chain_two_select, user_chain_one_select}, 32'h2);
      ctl.scan(1'b0, 8, 32'h0, seen);
      chk("chain two", seen, 32'h0);
      ctl.scan(1'b1, 5, 32'h05, seen);
      ctl.scan(1'b0, 32, 32'hc3a5_0f96, seen);
      chk("write valid", {31'h0, cfg_wr_valid}, 32'h1);
      chk("write data", cfg_wr_data, 32'hc3a5_0f96);
      @(posedge ref_clk);
      cfg_wr_ready <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("write drained", {31'h0, cfg_wr_valid}, 32'h0);
      cfg_rd_data <= 32'h6b1e_d2c4;
      cfg_rd_valid <= 1'b1;
      ctl.scan(1'b1, 5, 32'h04, seen);
      ctl.scan(1'b0, 32, 32'h0, seen);
      chk("readback", seen, 32'h6b1e_d2c4);
      close_out;
   end
endmodule : jtag_instruction_scan_registers_test
